// File: design/dsmcb_pkg.sv
// Shared constants for the set-maximum and set-block-size command block.
// Assumes an APB register bus with 32-bit data and byte addresses.
package dsmcb_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_FEATURE = 8'h00;
    localparam logic [7:0] OFS_SECCNT = 8'h04;
    localparam logic [7:0] OFS_SECNUM = 8'h08;
    localparam logic [7:0] OFS_CYLLO = 8'h0c;
    localparam logic [7:0] OFS_CYLHI = 8'h10;
    localparam logic [7:0] OFS_DEVCTL = 8'h14;
    localparam logic [7:0] OFS_COMMAND = 8'h18;
    localparam logic [7:0] OFS_ERROR = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_MULT = 8'h24;
    localparam logic [7:0] OFS_MAXLO = 8'h28;
    localparam logic [7:0] OFS_MAXHI = 8'h2c;
    localparam logic [7:0] OFS_ISTS = 8'h30;
    localparam logic [7:0] OFS_IMASK = 8'h34;
    localparam logic [7:0] OFS_CONFIG = 8'h38;
    localparam logic [7:0] CMD_RDNATIVE = 8'h27;
    localparam logic [7:0] CMD_SETMAX = 8'h37;
    localparam logic [7:0] CMD_SETMULT = 8'hc6;
    localparam int HOB_BIT = 7;
    localparam int PERSIST_BIT = 0;
    localparam int OFSMODE_BIT = 0;
    localparam int ERR_ABT_BIT = 2;
    localparam int ST_ERR_BIT = 0;
    localparam int ST_RDY_BIT = 6;
    localparam int ST_BSY_BIT = 7;
    localparam int MULT_EN_BIT = 8;
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ABORT_BIT = 1;
    localparam int BLK_W = 5;
    localparam logic [7:0] BLK_MAX = 8'h10;
    localparam logic [7:0] ERR_RESET = 8'h00;
    localparam logic [BLK_W-1:0] BLK_RESET = 5'h00;
    localparam logic [47:0] NATIVE_MAX_DEF = 48'h0000_0fff_ffff;
    typedef enum logic [0:0] {
        DSMCB_IDLE = 1'b0,
        DSMCB_EXEC = 1'b1
    } dsmcb_state_t;
endpackage

// File: design/dsmcb_nvstore.sv
// Nonvolatile copy of the maximum address.
// Assumes the system reset does not reach it; only nv_clr_n erases it.
`timescale 1ns/1ps
module dsmcb_nvstore #(
    parameter int LBA_W = 48
) (
    input wire logic core_clk,
    input wire logic ce,
    input wire logic nv_clr_n,
    input wire logic wr,
    input wire logic [LBA_W-1:0] wdata,
    output logic nv_valid,
    output logic [LBA_W-1:0] nv_max
);
    if (LBA_W < 1) begin : g_chk
        $error("dsmcb_nvstore: LBA_W must be positive");
    end

    logic valid_reg;
    logic [LBA_W-1:0] max_reg;

    // Kept apart from the power-on reset so a persistent maximum survives it.
    always_ff @(posedge core_clk) begin
        if (!nv_clr_n) begin
            valid_reg <= 1'b0;
            max_reg <= '0;
        end else if (ce && wr) begin
            valid_reg <= 1'b1;
            max_reg <= wdata;
        end
    end

    assign nv_valid = valid_reg;
    assign nv_max = max_reg;
endmodule

// File: design/dsmcb_top.sv
// Command block for the 48-bit set-maximum and set-block-size commands.
// Assumes an APB master on core_clk and a hard reset pin from outside.
`timescale 1ns/1ps
module dsmcb_top #(
    parameter logic [47:0] NATIVE_MAX = dsmcb_pkg::NATIVE_MAX_DEF
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dsmcb_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic hard_rst_pin,
    input wire logic nv_clr_n,
    output logic mult_en,
    output logic [dsmcb_pkg::BLK_W-1:0] mult_blk,
    output logic [47:0] max_lba
);
    if (NATIVE_MAX == 48'h0000_0000_0000) begin : g_chk
        $error("dsmcb_top: NATIVE_MAX must be nonzero");
    end

    dsmcb_pkg::dsmcb_state_t state_reg;
    dsmcb_pkg::dsmcb_state_t state_next;
    logic [2:0][7:0] cur_reg;
    logic [2:0][7:0] prv_reg;
    logic [7:0] sc_cur_reg;
    logic [7:0] sc_prv_reg;
    logic [7:0] feat_reg;
    logic hob_reg;
    logic [7:0] cmd_reg;
    logic [7:0] err_reg;
    logic ofs_mode_reg;
    logic pre_reg;
    logic nv_used_reg;
    logic mult_en_reg;
    logic [dsmcb_pkg::BLK_W-1:0] mult_blk_reg;
    logic [47:0] max_reg;
    logic [dsmcb_pkg::IRQ_W-1:0] ists_reg;
    logic [dsmcb_pkg::IRQ_W-1:0] ists_next;
    logic [dsmcb_pkg::IRQ_W-1:0] imask_reg;
    logic irq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic hrst_s1_reg;
    logic hrst_s2_reg;
    logic nv_valid;
    logic [47:0] nv_max;

    // Bus decode. One wait state: pready rises in the second access cycle.
    wire acc = psel && penable;
    wire commit = acc && pready_reg;
    wire wr_go = commit && pwrite;
    wire rd_cap = acc && !pready_reg && !pwrite;
    wire busy = (state_reg == dsmcb_pkg::DSMCB_EXEC);
    wire tf_wr = wr_go && !busy;
    wire a_feat = (paddr == dsmcb_pkg::OFS_FEATURE);
    wire a_sc = (paddr == dsmcb_pkg::OFS_SECCNT);
    wire a_sn = (paddr == dsmcb_pkg::OFS_SECNUM);
    wire a_cl = (paddr == dsmcb_pkg::OFS_CYLLO);
    wire a_ch = (paddr == dsmcb_pkg::OFS_CYLHI);
    wire a_dc = (paddr == dsmcb_pkg::OFS_DEVCTL);
    wire a_cmd = (paddr == dsmcb_pkg::OFS_COMMAND);
    wire a_err = (paddr == dsmcb_pkg::OFS_ERROR);
    wire a_st = (paddr == dsmcb_pkg::OFS_STATUS);
    wire a_mult = (paddr == dsmcb_pkg::OFS_MULT);
    wire a_mlo = (paddr == dsmcb_pkg::OFS_MAXLO);
    wire a_mhi = (paddr == dsmcb_pkg::OFS_MAXHI);
    wire a_ists = (paddr == dsmcb_pkg::OFS_ISTS);
    wire a_imask = (paddr == dsmcb_pkg::OFS_IMASK);
    wire a_cfg = (paddr == dsmcb_pkg::OFS_CONFIG);
    // Unaligned or unknown offsets are unmapped and answer with pslverr.
    wire mapped = a_feat | a_sc | a_sn | a_cl | a_ch | a_dc | a_cmd |
        a_err | a_st | a_mult | a_mlo | a_mhi | a_ists | a_imask | a_cfg;
    wire [2:0] a_byte = {a_ch, a_cl, a_sn};

    // Command decode, evaluated in the execute cycle.
    wire is_rdnat = (cmd_reg == dsmcb_pkg::CMD_RDNATIVE);
    wire is_setmax = (cmd_reg == dsmcb_pkg::CMD_SETMAX);
    wire is_setmult = (cmd_reg == dsmcb_pkg::CMD_SETMULT);
    wire persist = sc_cur_reg[dsmcb_pkg::PERSIST_BIT];
    wire [47:0] req_lba = {prv_reg, cur_reg};
    wire bad_persist = persist &&
        (ofs_mode_reg || nv_used_reg);
    wire setmax_bad = !pre_reg || bad_persist ||
        (req_lba > NATIVE_MAX);
    wire [7:0] blk = sc_cur_reg;
    wire blk_ok = (blk == 8'h00) || ((blk <= dsmcb_pkg::BLK_MAX) &&
        ((blk & (blk - 8'h01)) == 8'h00));
    wire cmd_abort = is_setmax ? setmax_bad :
        is_setmult ? !blk_ok : !is_rdnat;
    wire exec = busy;
    wire max_ok = exec && is_setmax && !setmax_bad;
    wire nv_wr = max_ok && persist;
    wire ld_tf = exec && (is_rdnat || max_ok);
    wire [47:0] ld_val = is_rdnat ? NATIVE_MAX : req_lba;
    wire hard_rst = hrst_s2_reg;

    wire [dsmcb_pkg::IRQ_W-1:0] ev;
    assign ev[dsmcb_pkg::IRQ_DONE_BIT] = exec && !cmd_abort;
    assign ev[dsmcb_pkg::IRQ_ABORT_BIT] = exec && cmd_abort;
    wire [dsmcb_pkg::IRQ_W-1:0] w1c = (wr_go && a_ists) ?
        pwdata[dsmcb_pkg::IRQ_W-1:0] : '0;
    // A new event wins over a clear in the same cycle.
    assign ists_next = (ists_reg & ~w1c) | ev;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dsmcb_pkg::DSMCB_IDLE: begin
                if (tf_wr && a_cmd) begin
                    state_next = dsmcb_pkg::DSMCB_EXEC;
                end
            end
            dsmcb_pkg::DSMCB_EXEC: begin
                state_next = dsmcb_pkg::DSMCB_IDLE;
            end
            default: begin
                state_next = dsmcb_pkg::DSMCB_IDLE;
            end
        endcase
    end

    // Read mux. HOB chooses the previous half of the address bytes.
    wire [7:0] rd_sc = hob_reg ? sc_prv_reg : sc_cur_reg;
    wire [7:0] rd_sn = hob_reg ? prv_reg[0] : cur_reg[0];
    wire [7:0] rd_cl = hob_reg ? prv_reg[1] : cur_reg[1];
    wire [7:0] rd_ch = hob_reg ? prv_reg[2] : cur_reg[2];
    wire [7:0] st_val = {busy, 1'b1, 5'h00,
        err_reg[dsmcb_pkg::ERR_ABT_BIT]};
    wire [31:0] rd_val =
        a_feat ? {24'h000000, feat_reg} :
        a_sc ? {24'h000000, rd_sc} :
        a_sn ? {24'h000000, rd_sn} :
        a_cl ? {24'h000000, rd_cl} :
        a_ch ? {24'h000000, rd_ch} :
        a_dc ? {24'h000000, hob_reg, 7'h00} :
        a_cmd ? {24'h000000, cmd_reg} :
        a_err ? {24'h000000, err_reg} :
        a_st ? {24'h000000, st_val} :
        a_mult ? {23'h000000, mult_en_reg, 3'h0, mult_blk_reg} :
        a_mlo ? max_reg[31:0] :
        a_mhi ? {16'h0000, max_reg[47:32]} :
        a_ists ? {30'h00000000, ists_reg} :
        a_imask ? {30'h00000000, imask_reg} :
        a_cfg ? {31'h00000000, ofs_mode_reg} :
        32'h00000000;

    // Read data is caught in the first access cycle so it stands with pready.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else if (ce) begin
            pready_reg <= acc && !pready_reg;
            pslverr_reg <= acc && !pready_reg && !mapped;
            if (rd_cap) begin
                prdata_reg <= rd_val;
            end
        end
    end

    // The hard reset pin is asynchronous to core_clk.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            hrst_s1_reg <= 1'b0;
            hrst_s2_reg <= 1'b0;
        end else if (ce) begin
            hrst_s1_reg <= hard_rst_pin;
            hrst_s2_reg <= hrst_s1_reg;
        end
    end

    // Address bytes: a host write pushes the old value into the previous half.
    for (genvar i = 0; i < 3; i++) begin : g_tf
        always_ff @(posedge core_clk) begin
            if (!nrst) begin
                cur_reg[i] <= 8'h00;
                prv_reg[i] <= 8'h00;
            end else if (ce) begin
                if (ld_tf) begin
                    cur_reg[i] <= ld_val[8*i +: 8];
                    prv_reg[i] <= ld_val[24 + 8*i +: 8];
                end else if (tf_wr && a_byte[i]) begin
                    prv_reg[i] <= cur_reg[i];
                    cur_reg[i] <= pwdata[7:0];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sc_cur_reg <= 8'h00;
            sc_prv_reg <= 8'h00;
            feat_reg <= 8'h00;
            hob_reg <= 1'b0;
            cmd_reg <= 8'h00;
            ofs_mode_reg <= 1'b0;
            imask_reg <= '0;
        end else if (ce) begin
            if (tf_wr && a_sc) begin
                sc_prv_reg <= sc_cur_reg;
                sc_cur_reg <= pwdata[7:0];
            end
            if (tf_wr && a_feat) begin
                feat_reg <= pwdata[7:0];
            end
            if (wr_go && a_dc) begin
                hob_reg <= pwdata[dsmcb_pkg::HOB_BIT];
            end
            if (tf_wr && a_cmd) begin
                cmd_reg <= pwdata[7:0];
            end
            if (wr_go && a_cfg) begin
                ofs_mode_reg <= pwdata[dsmcb_pkg::OFSMODE_BIT];
            end
            if (wr_go && a_imask) begin
                imask_reg <= pwdata[dsmcb_pkg::IRQ_W-1:0];
            end
        end
    end

    // Execution and its results. Every command clears the old error.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_reg <= dsmcb_pkg::DSMCB_IDLE;
            err_reg <= dsmcb_pkg::ERR_RESET;
        end else if (ce) begin
            state_reg <= state_next;
            if (exec) begin
                err_reg <= dsmcb_pkg::ERR_RESET;
                err_reg[dsmcb_pkg::ERR_ABT_BIT] <= cmd_abort;
            end
        end
    end

    // A hard reset ends the read-native window, so a set-maximum that
    // follows it is refused until a fresh read-native.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pre_reg <= 1'b0;
        end else if (ce) begin
            if (exec) begin
                pre_reg <= is_rdnat;
            end else if (hard_rst) begin
                pre_reg <= 1'b0;
            end
        end
    end

    // Any set-multiple, good or bad, rewrites both fields, so an illegal
    // size can never leave an older size enabled.
    wire blk_take = exec && is_setmult;
    wire blk_on = blk_ok && (blk != 8'h00);
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mult_en_reg <= 1'b0;
            mult_blk_reg <= dsmcb_pkg::BLK_RESET;
        end else if (ce && blk_take) begin
            if (blk_on) begin
                mult_en_reg <= 1'b1;
                mult_blk_reg <= blk[dsmcb_pkg::BLK_W-1:0];
            end else begin
                mult_en_reg <= 1'b0;
                mult_blk_reg <= dsmcb_pkg::BLK_RESET;
            end
        end
    end

    // The working maximum falls back to the persistent copy (NATIVE_MAX when none is valid) at power-on,
    // so a volatile setting is lost there.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            max_reg <= nv_valid ? nv_max : NATIVE_MAX;
            nv_used_reg <= 1'b0;
        end else if (ce) begin
            if (max_ok) begin
                max_reg <= req_lba;
            end
            if (hard_rst) begin
                nv_used_reg <= 1'b0;
            end else if (nv_wr) begin
                nv_used_reg <= 1'b1;
            end
        end
    end

    // The line is taken from the next status so it rises with the bit.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ists_reg <= '0;
            irq_reg <= 1'b0;
        end else if (ce) begin
            ists_reg <= ists_next;
            irq_reg <= |(ists_next & imask_reg);
        end
    end

    dsmcb_nvstore #(
        .LBA_W(48)
    ) u_nv (
        .core_clk(core_clk),
        .ce(ce),
        .nv_clr_n(nv_clr_n),
        .wr(nv_wr && !ofs_mode_reg),
        .wdata(req_lba),
        .nv_valid(nv_valid),
        .nv_max(nv_max)
    );

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign mult_en = mult_en_reg;
    assign mult_blk = mult_blk_reg;
    assign max_lba = max_reg;
endmodule

// File: dv/dsmcb_monitor.sv
// Port-level assertions for the command block.
// Assumes the single core_clk domain and the synchronous reset nrst.
`timescale 1ns/1ps
module dsmcb_monitor (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dsmcb_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mult_en,
    input wire logic [dsmcb_pkg::BLK_W-1:0] mult_blk,
    input wire logic [47:0] max_lba
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    wire cmd_wr = psel && penable && pready && pwrite &&
        paddr == dsmcb_pkg::OFS_COMMAND;
    wire go_max = cmd_wr && pwdata[7:0] == dsmcb_pkg::CMD_SETMAX;
    wire go_blk = cmd_wr && pwdata[7:0] == dsmcb_pkg::CMD_SETMULT;
    wire rd_ok = pready && !pwrite;
    wait_state_a:
        assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not on the second access cycle");
    ready_once_a: assert property (pready |=> !pready)
        else $error("pready held");
    slverr_map_a:
        assert property (pslverr || pready |->
            pready && pslverr == (paddr > dsmcb_pkg::OFS_CONFIG ||
                paddr[1:0] != 2'h0))
        else $error("wrong slave error");
    blk_off_a:
        assert property (!mult_en |-> mult_blk == 5'h00)
        else $error("block size while disabled");
    blk_legal_a:
        assert property (mult_en |->
            mult_blk inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
        else $error("illegal block size enabled");
    lba_cause_a:
        assert property ($past(nrst) && $changed(max_lba) |->
            $past(go_max) || $past(go_max, 2) || $past(go_max, 3))
        else $error("maximum moved without set-max");
    mult_cause_a:
        assert property ($past(nrst) && $changed({mult_en, mult_blk}) |->
            $past(go_blk) || $past(go_blk, 2) || $past(go_blk, 3))
        else $error("block size moved without set-multiple");
    err_val_a:
        assert property (rd_ok && paddr == dsmcb_pkg::OFS_ERROR |->
            prdata == 32'h0 || prdata == 32'h4)
        else $error("error flags beyond abort");
    st_fmt_a:
        assert property (rd_ok && paddr == dsmcb_pkg::OFS_STATUS |->
            prdata[31:8] == 24'h0 && prdata[dsmcb_pkg::ST_RDY_BIT] &&
            !prdata[5] && !prdata[2])
        else $error("status fixed bits wrong");
endmodule

// File: dv/dsmcb_host.sv
// Host adapter model: an APB master issuing task-file accesses.
// Assumes the slave answers with pready; the bench bounds every wait.
`timescale 1ns/1ps
module dsmcb_host (
    input wire logic core_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [dsmcb_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released address and data lines flip so a stale value can never pass as fresh.
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// File: dv/dsmcb_top_test.sv
// Self-checking bench for the set-maximum and set-multiple commands.
// Assumes the host model in dsmcb_host and the checker dsmcb_monitor.
`timescale 1ns/1ps
module dsmcb_top_test;
    localparam logic [47:0] NMAX = 48'hffff_ffff_fffe;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic hard_rst_pin = 1'b0;
    logic nv_clr_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, mult_en, rd_e, ok;
    logic [dsmcb_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [dsmcb_pkg::BLK_W-1:0] mult_blk;
    logic [47:0] max_lba, cur_max, v, pv;
    logic [7:0] s;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 68597;
    int n;
    initial forever #5 core_clk = ~core_clk;
    dsmcb_top #(.NATIVE_MAX(NMAX)) dut (.core_clk(core_clk), .nrst(nrst),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .hard_rst_pin(hard_rst_pin),
        .nv_clr_n(nv_clr_n), .mult_en(mult_en), .mult_blk(mult_blk),
        .max_lba(max_lba));
    dsmcb_host host (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    task chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] mult_exp(input logic [7:0] sz);
        logic good;
        good = sz inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
        return {23'h0, good && sz != 8'h00, 3'h0, good ? sz[4:0] : 5'h00};
    endfunction
    task results;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task w(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd_q, rd_e);
    endtask
    task r(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, rd_q, rd_e);
    endtask
    task cmd(input logic [7:0] c, input logic ab);
        w(dsmcb_pkg::OFS_COMMAND, {24'h0, c});
        r(dsmcb_pkg::OFS_STATUS);
        chk(rd_q[dsmcb_pkg::ST_ERR_BIT], ab);
        r(dsmcb_pkg::OFS_ERROR);
        chk(rd_q, ab ? 32'h4 : 32'h0);
        // Only the abort event is unmasked, so irq follows ab alone.
        chk(irq, ab);
        r(dsmcb_pkg::OFS_ISTS);
        chk(rd_q, {30'h0, ab, !ab});
        w(dsmcb_pkg::OFS_ISTS, 32'h3);
    endtask
    task smax(input logic [47:0] a, input logic b, input logic ab);
        int i;
        logic [7:0] ad;
        cmd(dsmcb_pkg::CMD_RDNATIVE, 1'b0);
        w(dsmcb_pkg::OFS_SECCNT, {31'h0, b});
        for (i = 0; i < 3; i++) begin
            ad = 8'(dsmcb_pkg::OFS_SECNUM + 4 * i);
            w(ad, {24'h0, a[24+8*i+:8]});
            w(ad, {24'h0, a[8*i+:8]});
        end
        cmd(dsmcb_pkg::CMD_SETMAX, ab);
        if (!ab) cur_max = a;
        chk(max_lba, cur_max);
        for (i = 0; i < 6 && !ab; i++) begin
            w(dsmcb_pkg::OFS_DEVCTL, {24'h0, i[0], 7'h0});
            r(8'(dsmcb_pkg::OFS_SECNUM + 4 * (i / 2)));
            chk(rd_q, {24'h0, cur_max[8*(i/2)+24*i[0]+:8]});
        end
        w(dsmcb_pkg::OFS_DEVCTL, 32'h0);
    endtask
    task rst;
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("Error at %0t: run did not finish", $time);
            results;
        end
    end
    initial begin
        // The persistent copy has no power-on value; erase it under reset.
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        nv_clr_n <= 1'b1;
        @(posedge core_clk);
        cur_max = NMAX;
        chk(max_lba, NMAX);
        r(8'h3c);
        chk({rd_e, rd_q}, 48'h1_0000_0000);
        w(dsmcb_pkg::OFS_IMASK, 32'h2);
        for (n = 0; n < 40; n++) begin
            s = n < 18 ? 8'(n) : 8'($random(seed));
            ok = s inside {0, 1, 2, 4, 8, 16};
            w(dsmcb_pkg::OFS_SECCNT, {24'h0, s});
            cmd(dsmcb_pkg::CMD_SETMULT, !ok);
            r(dsmcb_pkg::OFS_MULT);
            chk(rd_q, mult_exp(s));
            chk(mult_blk, ok ? s[4:0] : 5'h0);
            chk(mult_en, ok && s != 0);
        end
        for (n = 0; n < 4; n++) begin
            v = {16'($random(seed)), 32'($random(seed))};
            smax(v > NMAX ? NMAX : v, 1'b0, 1'b0);
        end
        smax(NMAX, 1'b0, 1'b0);
        smax(NMAX + 48'h1, 1'b0, 1'b1);
        cmd(dsmcb_pkg::CMD_SETMAX, 1'b1);
        w(dsmcb_pkg::OFS_CONFIG, 32'h1);
        smax(v >> 1, 1'b1, 1'b1);
        w(dsmcb_pkg::OFS_CONFIG, 32'h0);
        smax(v >> 2, 1'b1, 1'b0);
        smax(v >> 3, 1'b1, 1'b1);
        @(posedge core_clk);
        hard_rst_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        hard_rst_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        pv = v >> 4;
        smax(pv, 1'b1, 1'b0);
        smax(v >> 5, 1'b0, 1'b0);
        rst;
        chk(max_lba, pv);
        @(posedge core_clk);
        nv_clr_n <= 1'b0;
        @(posedge core_clk);
        nv_clr_n <= 1'b1;
        rst;
        chk(max_lba, NMAX);
        results;
    end
endmodule
bind dsmcb_top dsmcb_monitor mon (.core_clk(core_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mult_en(mult_en), .mult_blk(mult_blk), .max_lba(max_lba));
